// *** rtl/rpu_pkg.sv ***
// package for the region protection unit: register map, descriptor layout,
// bus request carriers. assumes a 32-bit axi4-lite register port.
package rpu_pkg;

  localparam int NUM_REGIONS = 16;
  localparam int NUM_PORTS = 2;
  localparam int REGION_GRAIN = 5;

  // register map (byte addresses)
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] IRQ_STAT_OFFS = 12'h004;
  localparam logic [11:0] IRQ_CLR_OFFS = 12'h008;
  localparam logic [11:0] IRQ_EN_OFFS = 12'h00c;
  localparam logic [11:0] ERR_BASE_OFFS = 12'h010;
  localparam logic [11:0] ERR_STRIDE = 12'h008;
  localparam logic [11:0] DESC_BASE_OFFS = 12'h400;
  localparam logic [11:0] ALT_BASE_OFFS = 12'h800;

  // access word fields: cpu supervisor rwx, cpu user rwx, other masters rw
  localparam int AC_SUP_R = 0;
  localparam int AC_SUP_W = 1;
  localparam int AC_SUP_X = 2;
  localparam int AC_USR_R = 3;
  localparam int AC_USR_W = 4;
  localparam int AC_USR_X = 5;
  localparam int AC_DMA_R = 6;
  localparam int AC_DMA_W = 7;
  localparam int AC_OTH_R = 8;
  localparam int AC_OTH_W = 9;
  localparam int DESC_VALID_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    MASTER_CPU = 2'b00,
    MASTER_DMA = 2'b01,
    MASTER_OTHER = 2'b10
  } master_id_t;

  typedef enum logic [1:0] {
    ACC_READ = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_EXEC = 2'b10
  } acc_kind_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    master_id_t master;
    logic supervisor;
    acc_kind_t kind;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] region_hits;
    logic [19:0] detail;
    master_id_t master;
    logic supervisor;
    acc_kind_t kind;
    logic unmapped;
    logic [1:0] spare;
  } err_capture_t;

endpackage

// *** rtl/region_protection_unit.sv ***
// region protection unit guarding the sram and peripheral bridge ports.
// assumes requests arrive synchronous to REF_CLK, one per port per cycle,
// and that the crossbar_switch holds a request until it sees the verdict.
//
// Function
// RQ1: sixteen region descriptors of 128 bits each.
// RQ2: regions bounded by start and end, 32-byte grain, up to 4 GB.
// RQ3: unit disabled after reset, nothing is blocked until enabled.
// RQ4: cpu gets separate read, write, execute for supervisor and user.
// RQ5: other masters get read and write only.
// RQ6: descriptor valid bit cleared on write, set when the word completes.
// RQ7: alias access word writes rights only, bounds untouched.
// RQ8: any granting overlapping region wins over denying ones.
// RQ9: sram and bridge ports checked concurrently.
// RQ10: error when no valid region hits or all hits deny.
// RQ11: error ends the transaction and blocks the slave cycle.
// RQ12: 64-bit capture per port for the last faulting reference.
// RQ13: permitted references pass unaltered.
// RQ14: master id and mode select the permission set.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module region_protection_unit
  import rpu_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // axi4-lite register port
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // monitored crossbar_switch slave ports: 0 sram, 1 peripheral_bridge_port
  input wire rpu_pkg::bus_req_t PORT_REQ [rpu_pkg::NUM_PORTS],
  output logic [rpu_pkg::NUM_PORTS-1:0] PORT_PASS,
  output logic [rpu_pkg::NUM_PORTS-1:0] PORT_ERROR,
  // interrupt
  output logic IRQ
);
  import rpu_pkg::*;

  logic rst_meta_q, rst_n_q;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // descriptor storage: word0 start, word1 end, word2 access, word3 valid
  logic [31:0] desc_q [NUM_REGIONS][4]; // RQ1
  logic enable_q;
  err_capture_t err_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] irq_stat_q, irq_en_q;

  // does region r grant request q
  function automatic logic region_grants(input bus_req_t q,
                                         input logic [31:0] s,
                                         input logic [31:0] e,
                                         input logic [31:0] ac,
                                         input logic v);
    logic in_range, ok;
    in_range = v && (q.addr[31:REGION_GRAIN] >= s[31:REGION_GRAIN]) &&
               (q.addr[31:REGION_GRAIN] <= e[31:REGION_GRAIN]); // RQ2
    ok = 1'b0;
    case (q.master) // RQ14
      MASTER_CPU: begin
        if (q.supervisor) begin // RQ4
          ok = (q.kind == ACC_READ) ? ac[AC_SUP_R] :
               (q.kind == ACC_WRITE) ? ac[AC_SUP_W] : ac[AC_SUP_X];
        end else begin
          ok = (q.kind == ACC_READ) ? ac[AC_USR_R] :
               (q.kind == ACC_WRITE) ? ac[AC_USR_W] : ac[AC_USR_X];
        end
      end
      MASTER_DMA: begin
        // no execute right exists for non-core masters
        ok = (q.kind == ACC_READ) ? ac[AC_DMA_R] :
             (q.kind == ACC_WRITE) ? ac[AC_DMA_W] : 1'b0; // RQ5
      end
      default: begin
        ok = (q.kind == ACC_READ) ? ac[AC_OTH_R] :
             (q.kind == ACC_WRITE) ? ac[AC_OTH_W] : 1'b0; // RQ5
      end
    endcase
    return in_range && ok;
  endfunction

  function automatic logic region_hits(input bus_req_t q,
                                       input logic [31:0] s,
                                       input logic [31:0] e,
                                       input logic v);
    return v && (q.addr[31:REGION_GRAIN] >= s[31:REGION_GRAIN]) &&
           (q.addr[31:REGION_GRAIN] <= e[31:REGION_GRAIN]);
  endfunction

  // checking, both ports in parallel
  logic [NUM_PORTS-1:0] granted, any_hit, fault;
  logic [NUM_REGIONS-1:0] hit_vec [NUM_PORTS];
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin // RQ9
      granted[p] = 1'b0;
      hit_vec[p] = '0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
        hit_vec[p][r] = region_hits(PORT_REQ[p], desc_q[r][0],
                                    desc_q[r][1],
                                    desc_q[r][3][DESC_VALID_BIT]);
        // one granting region is enough, whatever the others say
        granted[p] = granted[p] |
          region_grants(PORT_REQ[p], desc_q[r][0], desc_q[r][1],
                        desc_q[r][2], desc_q[r][3][DESC_VALID_BIT]); // RQ8
      end
      any_hit[p] = |hit_vec[p];
      fault[p] = PORT_REQ[p].valid && enable_q && !granted[p]; // RQ10 RQ3
      PORT_PASS[p] = PORT_REQ[p].valid && !fault[p]; // RQ13 RQ11
      PORT_ERROR[p] = fault[p]; // RQ11
    end
  end

  // fault capture: last fault per port, overwritten by each new one
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int p = 0; p < NUM_PORTS; p++) err_q[p] <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (fault[p]) begin // RQ12
          err_q[p].addr <= PORT_REQ[p].addr;
          err_q[p].region_hits <= 4'(hit_vec[p]);
          err_q[p].detail <= {4'h0, hit_vec[p]};
          err_q[p].master <= PORT_REQ[p].master;
          err_q[p].supervisor <= PORT_REQ[p].supervisor;
          err_q[p].kind <= PORT_REQ[p].kind;
          err_q[p].unmapped <= !any_hit[p];
          err_q[p].spare <= 2'h0;
        end
      end
    end
  end

  // axi4-lite write path: address and data accepted in either order
  logic aw_held_q, w_held_q, bvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [1:0] bresp_q;
  logic wr_go;
  logic [1:0] wr_resp;
  assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
  assign S_AXI_WREADY = !w_held_q && !bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;

  function automatic logic [1:0] decode_resp(input logic [11:0] a);
    if (a == CTRL_OFFS || a == IRQ_STAT_OFFS || a == IRQ_CLR_OFFS ||
        a == IRQ_EN_OFFS) begin
      return RESP_OKAY;
    end else if (a >= ERR_BASE_OFFS &&
                 a < ERR_BASE_OFFS + 12'(NUM_PORTS) * ERR_STRIDE) begin
      return RESP_OKAY;
    end else if (a >= DESC_BASE_OFFS &&
                 a < DESC_BASE_OFFS + 12'(NUM_REGIONS * 16)) begin
      return RESP_OKAY;
    end else if (a >= ALT_BASE_OFFS &&
                 a < ALT_BASE_OFFS + 12'(NUM_REGIONS * 4)) begin
      return RESP_OKAY;
    end else begin
      return RESP_DECERR;
    end
  endfunction

  assign wr_resp = decode_resp({awaddr_q[11:2], 2'b00});

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      bresp_q <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // register writes; byte strobes are ignored, words are written whole
  logic [11:0] wa;
  logic [3:0] wr_idx;
  assign wa = {awaddr_q[11:2], 2'b00};
  assign wr_idx = wa[7:4];

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q <= 1'b0; // RQ3
      irq_en_q <= '0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
        for (int w = 0; w < 4; w++) desc_q[r][w] <= 32'h0000_0000;
      end
    end else if (wr_go && wr_resp == RESP_OKAY) begin
      if (wa == CTRL_OFFS) begin
        enable_q <= wdata_q[0];
      end else if (wa == IRQ_EN_OFFS) begin
        irq_en_q <= wdata_q[NUM_PORTS-1:0];
      end else if (wa >= ALT_BASE_OFFS) begin
        // alias: rights only, bounds and valid left as they are
        desc_q[wa[5:2]][2] <= wdata_q; // RQ7
      end else if (wa >= DESC_BASE_OFFS) begin
        if (wa[3:2] == 2'd3) begin
          // last word completes the descriptor
          desc_q[wr_idx][3] <= wdata_q; // RQ6
        end else begin
          desc_q[wr_idx][wa[3:2]] <= wdata_q;
          // a half-written descriptor must never match
          desc_q[wr_idx][3][DESC_VALID_BIT] <= 1'b0; // RQ6
        end
      end
    end
  end

  // sticky fault status: a new fault wins over a clear in the same cycle
  logic [NUM_PORTS-1:0] clr_bits;
  assign clr_bits = (wr_go && wa == IRQ_CLR_OFFS) ?
                    wdata_q[NUM_PORTS-1:0] : '0;
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_bits) | fault;
    end
  end
  assign IRQ = |(irq_stat_q & irq_en_q);

  // axi4-lite read path
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [11:0] ra;
  logic [31:0] rd_val;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign ra = {S_AXI_ARADDR[11:2], 2'b00};

  always_comb begin
    rd_val = 32'h0000_0000;
    if (ra == CTRL_OFFS) begin
      rd_val = {31'h0, enable_q};
    end else if (ra == IRQ_STAT_OFFS) begin
      rd_val = {30'h0, irq_stat_q};
    end else if (ra == IRQ_EN_OFFS) begin
      rd_val = {30'h0, irq_en_q};
    end else if (ra >= ERR_BASE_OFFS && ra < DESC_BASE_OFFS) begin
      // lower word of a port pair holds attributes, upper the fault address
      rd_val = ra[2] ? err_q[ra[3]][63:32] : err_q[ra[3]][31:0];
    end else if (ra >= ALT_BASE_OFFS) begin
      rd_val = desc_q[ra[5:2]][2];
    end else if (ra >= DESC_BASE_OFFS) begin
      rd_val = desc_q[ra[7:4]][ra[3:2]];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= decode_resp(ra);
      rdata_q <= (decode_resp(ra) == RESP_OKAY) ? rd_val : 32'h0000_0000;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// *** test/crossbar_switch_model.sv ***
// protected slave side: counts forwarded bus cycles and error endings.
// assumes each verdict holds for one REF_CLK edge per offered request.
`timescale 1ns/1ps
module crossbar_switch_model (
  // clock
  input wire logic clk,
  // verdicts from the unit
  input wire logic [1:0] pass,
  input wire logic [1:0] error,
  // tallies
  output int slave_cycles,
  output int err_ends
);
  // a slave cycle only ever starts on a pass, so blocked ones never count
  always @(posedge clk) begin
    slave_cycles <= slave_cycles + pass[0] + pass[1];
    err_ends <= err_ends + error[0] + error[1];
  end
endmodule

// *** test/region_protection_unit_checker.sv ***
// assertions on the region protection unit pins, bound to its top.
// assumes one clock domain with RESET_N as its only reset.
`timescale 1ns/1ps
module region_protection_unit_checker
  import rpu_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  // monitored ports
  input wire rpu_pkg::bus_req_t PORT_REQ [rpu_pkg::NUM_PORTS],
  input wire logic [1:0] PORT_PASS,
  input wire logic [1:0] PORT_ERROR,
  input wire logic IRQ
);
  logic wrote_q;
  logic [1:0] v;
  assign v = {PORT_REQ[1].valid, PORT_REQ[0].valid};
  // no register write yet means the unit cannot have been enabled
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wrote_q <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      wrote_q <= 1'b1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_excl;
    (PORT_PASS & PORT_ERROR) == 2'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("pass with error");
  property p_verdict;
    (PORT_PASS | PORT_ERROR) == v;
  endproperty
  a_verdict: assert property (p_verdict) else $error("no verdict");
  property p_open;
    !wrote_q |-> PORT_PASS == v;
  endproperty
  a_open: assert property (p_open) else $error("blocked at reset");
  property p_irq;
    $rose(IRQ) |-> $rose(S_AXI_BVALID) || $past(|PORT_ERROR);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_bans;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      ##1 1'b1 |=> S_AXI_BVALID;
  endproperty
  a_bans: assert property (p_bans) else $error("write unanswered");
  property p_bdrop;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_bdrop: assert property (p_bdrop) else $error("write answer stuck");
  property p_rans;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rans: assert property (p_rans) else $error("read unanswered");
  property p_arblk;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read taken twice");
  c_err: cover property (|PORT_ERROR);
  c_pass: cover property ((|PORT_PASS) && wrote_q);
  c_irq: cover property ($rose(IRQ));
endmodule
bind region_protection_unit region_protection_unit_checker chk_i (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .PORT_REQ(PORT_REQ), .PORT_PASS(PORT_PASS), .PORT_ERROR(PORT_ERROR),
  .IRQ(IRQ));

// *** test/region_protection_unit_tb.sv ***
// bench for the region protection unit: axi4-lite tasks and port checks.
// assumes a verdict appears in the cycle a request is offered.
`timescale 1ns/1ps
module region_protection_unit_tb;
  import rpu_pkg::*;
  localparam master_id_t cpu = MASTER_CPU, dma = MASTER_DMA;
  localparam master_id_t oth = MASTER_OTHER;
  localparam acc_kind_t ld = ACC_READ, st = ACC_WRITE, ex = ACC_EXEC;
  logic clk = 0;
  logic rst_n = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic awr, wr, bv, arr, rv, irq;
  logic [1:0] br, rr, pass, error;
  bus_req_t no = '0;
  bus_req_t req [NUM_PORTS] = '{default: '0};
  int err_total = 0, comparisons = 0, slv, errs;
  // region 0 wide with supervisor rw, region 1 minimal with no rights
  logic [11:0] ra [10] = '{12'h400, 12'h404, 12'h408, 12'h40c, 12'h410,
    12'h414, 12'h418, 12'h41c, 12'h00c, 12'h000};
  logic [31:0] rw [10] = '{32'h2000_0000, 32'h2000_0fff, 32'h3, 32'h1,
    32'h2000_0000, 32'h2000_001f, 32'h0, 32'h1, 32'h3, 32'h1};
  always #5 clk = ~clk;
  region_protection_unit DUT (.REF_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .PORT_REQ(req),
    .PORT_PASS(pass), .PORT_ERROR(error), .IRQ(irq));
  crossbar_switch_model slaves (.clk(clk), .pass(pass), .error(error),
    .slave_cycles(slv), .err_ends(errs));
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is looked at mid-cycle, so the release lands after the taking edge
  task automatic wr32(logic [11:0] a, logic [31:0] v, logic [1:0] e = 2'h0);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      if (tb) cmp("bresp", e, br);
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    bry <= 0;
  endtask
  task automatic rd32(string n, logic [11:0] a, logic [31:0] e,
                      logic [1:0] er = 2'h0);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      if (tr) cmp(n, e, rd);
      if (tr) cmp("rresp", er, rr);
      @(posedge clk);
      if (ta) arv <= 0;
    end
    rry <= 0;
  endtask
  task automatic chk(bus_req_t r0, bus_req_t r1, logic [1:0] p,
                     logic [1:0] e);
    @(posedge clk);
    req[0] <= r0;
    req[1] <= r1;
    @(negedge clk);
    cmp("pass", p, pass);
    cmp("error", e, error);
    @(posedge clk);
    req[0].valid <= 0;
    req[1].valid <= 0;
  endtask
  function automatic bus_req_t mk(logic [15:0] a, master_id_t m, logic s,
                                  acc_kind_t k);
    return '{1'b1, {16'h2000, a}, m, s, k};
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    chk(mk(16'h0, dma, 0, ex), mk(16'h40, oth, 0, st), 2'h3, 2'h0);
    foreach (ra[i]) wr32(ra[i], rw[i]);
    chk(mk(16'h10, cpu, 1, ld), mk(16'hff8, cpu, 1, st), 2'h3, 2'h0);
    chk(mk(16'h10, cpu, 0, ld), mk(16'h10, cpu, 1, ex), 2'h0, 2'h3);
    chk(mk(16'h1000, cpu, 1, ld), mk(16'h20, dma, 0, ld), 2'h0, 2'h3);
    rd32("capture0", 12'h014, 32'h2000_1000);
    rd32("capture1", 12'h01c, 32'h2000_0020);
    rd32("attr0", 12'h010, 32'h0000_0024);
    rd32("attr1", 12'h018, 32'h1000_0140);
    rd32("status", 12'h004, 32'h3);
    cmp("irq", 1, irq);
    wr32(12'h008, 32'h1);
    rd32("status", 12'h004, 32'h2);
    wr32(12'h00c, 32'h0);
    cmp("irq", 0, irq);
    wr32(12'h008, 32'h2);
    rd32("status", 12'h004, 32'h0);
    wr32(12'h800, 32'h3ff);
    chk(mk(16'h100, dma, 0, st), mk(16'h100, oth, 0, ex), 2'h1, 2'h2);
    chk(mk(16'h1000, cpu, 1, ld), mk(16'h100, cpu, 0, ex), 2'h2, 2'h1);
    wr32(12'h400, 32'h2000_0000);
    chk(mk(16'h10, dma, 0, ld), no, 2'h0, 2'h1);
    wr32(12'h40c, 32'h1);
    chk(mk(16'h10, dma, 0, ld), no, 2'h1, 2'h0);
    wr32(12'h300, 32'h1, 2'h3);
    rd32("unmapped", 12'h300, 32'h0, 2'h3);
    cmp("slave cycles", 7, slv);
    cmp("error ends", 7, errs);
    conclude();
  end
endmodule
